/* File: hdl/csb_pkg.sv */
// Constants for the core status and bank select register block.
// Assumes a single core clock and a 9-bit data memory address space.
package csb_pkg;

  // Data memory addressing
  localparam int unsigned CSB_ADDR_W    = 9;
  localparam int unsigned CSB_OFS_W     = 7;
  localparam int unsigned CSB_PTR_W     = 8;
  localparam int unsigned CSB_DATA_W    = 8;
  localparam int unsigned CSB_PCH_W     = 5;

  // Offsets within every bank (common registers)
  localparam logic [6:0] CSB_OFS_STATUS = 7'h03;
  localparam logic [6:0] CSB_OFS_PCH    = 7'h0A;

  // Field positions of core_status_flags
  localparam int unsigned CSB_BIT_CARRY    = 0;
  localparam int unsigned CSB_BIT_DCARRY   = 1;
  localparam int unsigned CSB_BIT_ZERO     = 2;
  localparam int unsigned CSB_BIT_PDOWN    = 3;
  localparam int unsigned CSB_BIT_TMOUT    = 4;
  localparam int unsigned CSB_BIT_DBANK_LO = 5;
  localparam int unsigned CSB_BIT_DBANK_HI = 6;
  localparam int unsigned CSB_BIT_IBANK    = 7;

  // Reset values and write masks
  localparam logic [7:0] CSB_STATUS_POR = 8'h18;
  localparam logic [7:0] CSB_MASK_BANK  = 8'hE0;
  localparam logic [7:0] CSB_MASK_SW    = 8'hE7;
  localparam logic [4:0] CSB_PCH_RST    = 5'h00;
  localparam logic [7:0] CSB_RD_ZERO    = 8'h00;

endpackage

/* File: hdl/csb_bank_map.sv */
// Registered data memory address forming from the bank select bits.
// Assumes bank bits and offsets come from logic on the same clock.
`timescale 1ns/1ps
module csb_bank_map
  import csb_pkg::*;
#(
  parameter int unsigned OFS_W = CSB_OFS_W,
  parameter int unsigned PTR_W = CSB_PTR_W
) (
  input  wire logic             core_clk_i,
  input  wire logic             reset_n_i,
  input  wire logic [1:0]       direct_bank_select_i,
  input  wire logic             indirect_bank_select_i,
  input  wire logic [OFS_W-1:0] direct_offset_i,
  input  wire logic [PTR_W-1:0] indirect_ptr_i,
  output logic      [OFS_W+1:0] direct_addr_o,
  output logic      [PTR_W:0]   indirect_addr_o
);

  ////////////////////////////////////////////////////////////////////////
  // Bank 0..3 is simply the top two bits of a 128-byte window
  logic [OFS_W+1:0] direct_addr_d;
  logic [PTR_W:0]   indirect_addr_d;

  assign direct_addr_d   = {direct_bank_select_i, direct_offset_i};
  assign indirect_addr_d = {indirect_bank_select_i, indirect_ptr_i};

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      direct_addr_o   <= '0;
      indirect_addr_o <= '0;
    end else begin
      direct_addr_o   <= direct_addr_d;
      indirect_addr_o <= indirect_addr_d;
    end
  end

endmodule

/* File: hdl/csb_status_bank.sv */
// Core status flags, bank select bits and program counter high latch.
// Assumes ALU, watchdog and sleep events are one-cycle pulses on
// core_clk_i; only the master clear pin is asynchronous.
`timescale 1ns/1ps
// Operation
// - Status register is an ordinary write destination
// - Flag-updating writes cannot change zero or carry flags
// - Timeout and powerdown flags ignore software writes
// - Clearing status zeroes bank bits, sets Z
// - Subtraction stores inverted borrow in C, DC
// - Indirect bank bit selects banks 2-3 or 0-1
// - Direct bank field selects 128-byte bank
// - Timeout flag set by power-up, clear, sleep
// - Timeout flag cleared on watchdog expiry
// - Powerdown flag set by power-up, watchdog clear
// - Powerdown flag cleared by sleep
// - Upper program counter byte is not addressable
// - High latch holds PC bits 12:8, transfers
// - Common registers decode in all four banks
// - Unimplemented locations and bits read zero
// - Pin and watchdog resets are non-power-up resets
module csb_status_bank
  import csb_pkg::*;
(
  input  wire logic                  core_clk_i,
  input  wire logic                  reset_n_i,
  input  wire logic [CSB_ADDR_W-1:0] reg_addr_i,
  input  wire logic [CSB_DATA_W-1:0] reg_wdata_i,
  input  wire logic                  reg_we_i,
  input  wire logic                  reg_re_i,
  output logic      [CSB_DATA_W-1:0] reg_rdata_o,
  input  wire logic                  alu_z_upd_i,
  input  wire logic                  alu_cdc_upd_i,
  input  wire logic                  alu_sub_i,
  input  wire logic                  alu_zero_i,
  input  wire logic                  alu_carry_i,
  input  wire logic                  alu_digit_carry_i,
  input  wire logic                  watchdog_clear_instruction_i,
  input  wire logic                  sleep_instruction_i,
  input  wire logic                  watchdog_timer_expire_i,
  input  wire logic                  watchdog_timer_reset_i,
  input  wire logic                  master_clear_pin_n_i,
  input  wire logic                  pc_load_i,
  output logic      [CSB_PCH_W-1:0]  pc_upper_o,
  input  wire logic [CSB_OFS_W-1:0]  direct_offset_i,
  input  wire logic [CSB_PTR_W-1:0]  indirect_ptr_i,
  output logic      [CSB_ADDR_W-1:0] direct_addr_o,
  output logic      [CSB_ADDR_W-1:0] indirect_addr_o,
  output logic      [CSB_DATA_W-1:0] status_o
);

  ////////////////////////////////////////////////////////////////////////
  // Master clear pin synchroniser
  logic pin_meta_q;
  logic pin_sync_q;

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pin_meta_q <= 1'b1;
      pin_sync_q <= 1'b1;
    end else begin
      pin_meta_q <= master_clear_pin_n_i;
      pin_sync_q <= pin_meta_q;
    end
  end

  // Warm reset holds for as long as the pin stays low
  logic warm_rst;
  assign warm_rst = !pin_sync_q || watchdog_timer_reset_i;

  ////////////////////////////////////////////////////////////////////////
  // Address decode; bank bits of the address are ignored on purpose
  logic sel_status;
  logic sel_pch;
  logic wr_status;
  logic wr_pch;
  logic flag_upd;

  assign sel_status = (reg_addr_i[6:0] == CSB_OFS_STATUS);
  assign sel_pch    = (reg_addr_i[6:0] == CSB_OFS_PCH);
  assign wr_status  = reg_we_i && sel_status;
  assign wr_pch     = reg_we_i && sel_pch;
  assign flag_upd   = alu_z_upd_i || alu_cdc_upd_i;

  ////////////////////////////////////////////////////////////////////////
  // Status register next value
  logic [7:0] status_q;
  logic [7:0] wr_mask;
  logic [7:0] status_wr;
  logic       carry_flag;
  logic       dcarry_flag;
  logic [7:0] status_d;

  // An instruction that also moves flags may only change the bank bits
  assign wr_mask   = flag_upd ? CSB_MASK_BANK : CSB_MASK_SW;
  assign status_wr = wr_status
                     ? ((status_q & ~wr_mask) | (reg_wdata_i & wr_mask))
                     : status_q;

  // Borrows arrive raw; stored inverted so the flags read as carries
  assign carry_flag  = alu_sub_i ? !alu_carry_i : alu_carry_i;
  assign dcarry_flag = alu_sub_i ? !alu_digit_carry_i
                                 : alu_digit_carry_i;

  always_comb begin
    status_d = status_wr;
    if (alu_z_upd_i) begin
      status_d[CSB_BIT_ZERO] = alu_zero_i;
    end
    if (alu_cdc_upd_i) begin
      status_d[CSB_BIT_CARRY]  = carry_flag;
      status_d[CSB_BIT_DCARRY] = dcarry_flag;
    end
    if (watchdog_clear_instruction_i) begin
      status_d[CSB_BIT_TMOUT] = 1'b1;
      status_d[CSB_BIT_PDOWN] = 1'b1;
    end
    if (sleep_instruction_i) begin
      status_d[CSB_BIT_TMOUT] = 1'b1;
      status_d[CSB_BIT_PDOWN] = 1'b0;
    end
    // Expiry wins: a lost timeout would hide a runaway program
    if (watchdog_timer_expire_i) begin
      status_d[CSB_BIT_TMOUT] = 1'b0;
    end
    if (warm_rst) begin
      status_d[CSB_BIT_IBANK:CSB_BIT_DBANK_LO] = 3'h0;
    end
  end

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      status_q <= CSB_STATUS_POR;
    end else begin
      status_q <= status_d;
    end
  end

  assign status_o = status_q;

  ////////////////////////////////////////////////////////////////////////
  // Program counter high latch; PC bits 12:8 have no address of their own
  logic [CSB_PCH_W-1:0] pch_q;
  logic [CSB_PCH_W-1:0] pch_d;
  logic [CSB_PCH_W-1:0] pc_upper_q;
  logic [CSB_PCH_W-1:0] pc_upper_d;

  assign pch_d      = warm_rst ? CSB_PCH_RST
                    : wr_pch   ? reg_wdata_i[CSB_PCH_W-1:0] : pch_q;
  assign pc_upper_d = warm_rst  ? CSB_PCH_RST
                    : pc_load_i ? pch_q : pc_upper_q;

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pch_q      <= CSB_PCH_RST;
      pc_upper_q <= CSB_PCH_RST;
    end else begin
      pch_q      <= pch_d;
      pc_upper_q <= pc_upper_d;
    end
  end

  assign pc_upper_o = pc_upper_q;

  ////////////////////////////////////////////////////////////////////////
  // Read port: data stands one cycle after the strobe, zero otherwise
  logic [7:0] rd_mux;
  logic [7:0] rdata_q;

  assign rd_mux = sel_status ? status_q
                : sel_pch    ? {3'h0, pch_q}
                : CSB_RD_ZERO;

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rdata_q <= CSB_RD_ZERO;
    end else begin
      rdata_q <= reg_re_i ? rd_mux : CSB_RD_ZERO;
    end
  end

  assign reg_rdata_o = rdata_q;

  ////////////////////////////////////////////////////////////////////////
  // Bank address forming
  csb_bank_map #(
    .OFS_W (CSB_OFS_W),
    .PTR_W (CSB_PTR_W)
  ) u_bank_map (
    .core_clk_i             (core_clk_i),
    .reset_n_i              (reset_n_i),
    .direct_bank_select_i   (status_q[CSB_BIT_DBANK_HI:CSB_BIT_DBANK_LO]),
    .indirect_bank_select_i (status_q[CSB_BIT_IBANK]),
    .direct_offset_i        (direct_offset_i),
    .indirect_ptr_i         (indirect_ptr_i),
    .direct_addr_o          (direct_addr_o),
    .indirect_addr_o        (indirect_addr_o)
  );

  ////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!reset_n_i);

  logic no_flag_evt;
  assign no_flag_evt = !watchdog_clear_instruction_i && !sleep_instruction_i
                       && !watchdog_timer_expire_i;

  sequence s_pch_write;
    wr_pch && !warm_rst;
  endsequence

  sequence s_pc_load;
    pc_load_i && !warm_rst && !wr_pch;
  endsequence

  // Pin low long enough to pass both synchroniser stages
  sequence s_pin_held;
    !master_clear_pin_n_i [*3];
  endsequence

  a_common_write: assert property (
    wr_status && !flag_upd && !warm_rst |=>
      status_o[7:5] == $past(reg_wdata_i[7:5]) &&
      status_o[1:0] == $past(reg_wdata_i[1:0]))
    else $error("status write in some bank not stored");

  a_flag_write_block: assert property (
    wr_status && alu_z_upd_i && !alu_cdc_upd_i |=>
      status_o[2] == $past(alu_zero_i) &&
      status_o[1:0] == $past(status_o[1:0]))
    else $error("write reached ALU-owned flag");

  a_reset_flags_ro: assert property (
    wr_status && no_flag_evt |=> $stable(status_o[4:3]))
    else $error("software changed timeout or powerdown flag");

  a_clear_status: assert property (
    wr_status && reg_wdata_i == 8'h00 && alu_z_upd_i && alu_zero_i &&
    !alu_cdc_upd_i && no_flag_evt |=>
      status_o[7:5] == 3'h0 && status_o[2] &&
      status_o[4:3] == $past(status_o[4:3]) &&
      status_o[1:0] == $past(status_o[1:0]))
    else $error("clear of status gave wrong value");

  a_sub_borrow: assert property (
    alu_cdc_upd_i && alu_sub_i |=>
      status_o[0] == !$past(alu_carry_i) &&
      status_o[1] == !$past(alu_digit_carry_i))
    else $error("borrow not stored inverted");

  a_indirect_bank: assert property (
    1'b1 |=> indirect_addr_o ==
      {$past(status_o[7]), $past(indirect_ptr_i)})
    else $error("indirect bank address wrong");

  a_direct_bank: assert property (
    1'b1 |=> direct_addr_o ==
      {$past(status_o[6:5]), $past(direct_offset_i)})
    else $error("direct bank address wrong");

  a_wdt_clear_flags: assert property (
    watchdog_clear_instruction_i && !watchdog_timer_expire_i |=>
      status_o[4:3] == 2'b11)
    else $error("watchdog clear did not set flags");

  a_sleep_flags: assert property (
    sleep_instruction_i && !watchdog_timer_expire_i |=>
      status_o[4] && !status_o[3])
    else $error("sleep left wrong flags");

  a_wdt_expire: assert property (
    watchdog_timer_expire_i |=> !status_o[4])
    else $error("expiry did not clear timeout flag");

  a_pch_transfer: assert property (
    s_pch_write ##1 s_pc_load |=>
      pc_upper_o == $past(reg_wdata_i[4:0], 2))
    else $error("latch value not moved to PC upper byte");

  a_unmapped_zero: assert property (
    reg_re_i && !sel_status && !sel_pch |=> reg_rdata_o == 8'h00)
    else $error("unimplemented location read nonzero");

  a_warm_reset: assert property (
    watchdog_timer_reset_i |=>
      status_o[7:5] == 3'h0 && pc_upper_o == 5'h00 &&
      (status_o[2:0] == $past(status_o[2:0]) || $past(flag_upd)))
    else $error("warm reset values wrong");

  a_pin_warm_reset: assert property (
    s_pin_held |=> status_o[7:5] == 3'h0 && pc_upper_o == 5'h00)
    else $error("pin reset left bank bits or PC upper set");

  a_read_status: assert property (
    reg_re_i && sel_status |=> reg_rdata_o == $past(status_o))
    else $error("status read in some bank gave wrong data");

  a_rdata_idle: assert property (
    !reg_re_i |=> reg_rdata_o == 8'h00)
    else $error("read data stood beyond its one cycle");

  a_pc_hold: assert property (
    !pc_load_i && !warm_rst |=> $stable(pc_upper_o))
    else $error("PC upper changed without a load");

endmodule

/* File: verification/csb_status_bank_bench.sv */
// Self-checking bench for the core status and bank select block.
// Assumes csb_pkg is compiled first; the bench drives every port itself.
`timescale 1ns/1ps
module cpu_status_bank_select_bench;
  import csb_pkg::*;

  localparam logic [10:0] ZU = 11'h001;
  localparam logic [10:0] CU = 11'h002;
  localparam logic [10:0] SB = 11'h004;
  localparam logic [10:0] ZR = 11'h008;
  localparam logic [10:0] CY = 11'h010;
  localparam logic [10:0] DG = 11'h020;
  localparam logic [10:0] WC = 11'h040;
  localparam logic [10:0] SL = 11'h080;
  localparam logic [10:0] EX = 11'h100;
  localparam logic [10:0] WR = 11'h200;
  localparam logic [10:0] PL = 11'h400;

  logic        core_clk     = 1'b0;
  logic        reset_n      = 1'b0;
  logic        master_clear_pin_n       = 1'b1;
  logic        we           = 1'b0;
  logic        re           = 1'b0;
  logic [8:0]  addr         = '0;
  logic [7:0]  wdata        = '0;
  logic [10:0] ev           = '0;
  logic [6:0]  offset       = '0;
  logic [7:0]  ptr          = '0;
  logic [7:0]  rdata;
  logic [7:0]  status;
  logic [4:0]  pc_upper;
  logic [8:0]  daddr;
  logic [8:0]  iaddr;
  int          errors       = 0;
  int          total_checks = 0;
  int          cycles       = 0;

  csb_status_bank dut_u (
    .core_clk_i                   (core_clk),
    .reset_n_i                    (reset_n),
    .reg_addr_i                   (addr),
    .reg_wdata_i                  (wdata),
    .reg_we_i                     (we),
    .reg_re_i                     (re),
    .reg_rdata_o                  (rdata),
    .alu_z_upd_i                  (ev[0]),
    .alu_cdc_upd_i                (ev[1]),
    .alu_sub_i                    (ev[2]),
    .alu_zero_i                   (ev[3]),
    .alu_carry_i                  (ev[4]),
    .alu_digit_carry_i            (ev[5]),
    .watchdog_clear_instruction_i (ev[6]),
    .sleep_instruction_i          (ev[7]),
    .watchdog_timer_expire_i      (ev[8]),
    .watchdog_timer_reset_i       (ev[9]),
    .master_clear_pin_n_i         (master_clear_pin_n),
    .pc_load_i                    (ev[10]),
    .pc_upper_o                   (pc_upper),
    .direct_offset_i              (offset),
    .indirect_ptr_i               (ptr),
    .direct_addr_o                (daddr),
    .indirect_addr_o              (iaddr),
    .status_o                     (status)
  );

  initial begin
    forever #20 core_clk = ~core_clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic end_of_test();
    $display("Checks %0d, mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Generous ceiling, the whole run needs about 93 cycles
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      errors++;
      end_of_test();
    end
  end

  task automatic chk(input string n, input logic [8:0] s, input logic [8:0] e);
    total_checks++;
    if (s !== e) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask

  // One bus write and/or event pulse, held exactly one cycle
  task automatic op(input logic w, input logic [8:0] a, input logic [7:0] d,
                    input logic [10:0] v);
    @(posedge core_clk);
    we <= w;
    addr <= a;
    wdata <= d;
    ev <= v;
    @(posedge core_clk);
    we <= 1'b0;
    ev <= '0;
    #1;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [8:0] a, input logic [7:0] e);
    @(posedge core_clk);
    re <= 1'b1;
    addr <= a;
    @(posedge core_clk);
    re <= 1'b0;
    #1;
    chk("read data", 9'(rdata), 9'(e));
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    @(posedge core_clk);
    #1;
    chk("status", 9'(status), 9'h018);
    chk("pc upper", 9'(pc_upper), 9'h000);
    $display("reset test done");
  endtask

  task automatic t_banks();
    op(1'b1, 9'h103, 8'h60, '0);
    rd(9'h003, 8'h78);
    rd(9'h083, 8'h78);
    rd(9'h183, 8'h78);
    op(1'b1, 9'h083, 8'hE7, '0);
    chk("status", 9'(status), 9'h0FF);
    $display("bank decode test done");
  endtask

  task automatic t_alu();
    // Clear-file form: Z set, carries and reset causes kept
    op(1'b1, 9'h003, 8'h00, ZU | ZR);
    chk("status", 9'(status), 9'h01F);
    op(1'b1, 9'h003, 8'h00, CU | SB | CY);
    chk("status", 9'(status), 9'h01E);
    op(1'b0, 9'h000, 8'h00, ZU | CU | CY);
    chk("status", 9'(status), 9'h019);
    op(1'b0, 9'h000, 8'h00, CU | DG);
    chk("status", 9'(status), 9'h01A);
    op(1'b0, 9'h000, 8'h00, CU | CY);
    chk("status", 9'(status), 9'h019);
    $display("alu flag test done");
  endtask

  task automatic t_events();
    logic [10:0] evs [5] = '{EX, SL, WC, EX | SL, WC};
    logic [7:0]  exs [5] = '{8'h09, 8'h11, 8'h19, 8'h01, 8'h19};
    for (int i = 0; i < 5; i++) begin
      op(1'b0, 9'h000, 8'h00, evs[i]);
      chk("status", 9'(status), 9'(exs[i]));
    end
    $display("reset cause test done");
  endtask

  task automatic t_latch();
    op(1'b1, 9'h18A, 8'hFF, '0);
    rd(9'h00A, 8'h1F);
    op(1'b0, 9'h000, 8'h00, PL);
    chk("pc upper", 9'(pc_upper), 9'h01F);
    // Latch write and load back to back, no idle cycle between
    @(posedge core_clk);
    we    <= 1'b1;
    addr  <= 9'h08A;
    wdata <= 8'h0A;
    @(posedge core_clk);
    we <= 1'b0;
    ev <= PL;
    @(posedge core_clk);
    ev <= '0;
    #1;
    chk("pc upper", 9'(pc_upper), 9'h00A);
    rd(9'h002, 8'h00);
    op(1'b1, 9'h105, 8'hFF, '0);
    rd(9'h185, 8'h00);
    chk("status", 9'(status), 9'h019);
    $display("latch test done");
  endtask

  task automatic t_map();
    logic [7:0] d;
    for (int i = 0; i < 8; i++) begin
      d = {3'(i), 5'h19};
      @(posedge core_clk);
      offset <= 7'h7F - 7'(i * 9);
      ptr <= 8'hA5 ^ 8'(i);
      op(1'b1, 9'h003, d, '0);
      @(posedge core_clk);
      #1;
      chk("direct addr", daddr, {d[6:5], 7'h7F - 7'(i * 9)});
      chk("indirect addr", iaddr, {d[7], 8'hA5 ^ 8'(i)});
    end
    $display("bank map test done");
  endtask

  task automatic t_warm();
    op(1'b0, 9'h000, 8'h00, WR);
    chk("status", 9'(status), 9'h019);
    chk("pc upper", 9'(pc_upper), 9'h000);
    op(1'b1, 9'h003, 8'hE1, '0);
    // Pin passes a two-stage synchroniser, so allow settling edges
    @(posedge core_clk);
    master_clear_pin_n <= 1'b0;
    repeat (4) @(posedge core_clk);
    master_clear_pin_n <= 1'b1;
    repeat (3) @(posedge core_clk);
    #1;
    chk("status", 9'(status), 9'h019);
    $display("warm reset test done");
  endtask

  initial begin
    repeat (3) @(posedge core_clk);
    reset_n <= 1'b1;
    t_reset();
    t_banks();
    t_alu();
    t_events();
    t_latch();
    t_map();
    t_warm();
    end_of_test();
  end
endmodule
